// file: design/macs_slice.v
`include "macs_consts.vh"

module macs_slice
(
  // clock and reset
  input  wire                       i_clk_sys,
  input  wire                       i_sys_rst,
  // static configuration, captured while reset is high
  input  wire [1:0]                 i_mode,
  input  wire                       i_signed,
  // operation request
  input  wire                       i_valid,
  input  wire [1:0]                 i_op,
  input  wire [`MACS_A_W-1:0]       i_data_a,
  input  wire [`MACS_B_W-1:0]       i_data_b,
  input  wire [`MACS_RES_W-1:0]     i_addend,
  input  wire [4*`MACS_SHAMT_W-1:0] i_shift_amt,
  // results
  output reg                        o_valid_ff,
  output reg  [`MACS_RES_W-1:0]     o_result_ff,
  output reg  [1:0]                 o_mode_ff,
  output reg                        o_signed_ff
);

  reg  [`MACS_RES_W-1:0] acc_ff;
  reg  [`MACS_RES_W-1:0] nxt_acc;
  reg  [`MACS_RES_W-1:0] nxt_res;

  // add stage on a full word; the caller masks to the lane width
  function [47:0] lane_op;
    input [1:0]  op;
    input [47:0] p;
    input [47:0] c;
    input [47:0] acc;
    begin
      case (op)
        `MACS_OP_ADD: lane_op = p + c;
        `MACS_OP_SUB: lane_op = p - c;
        `MACS_OP_ACC: lane_op = acc + p;
        default:      lane_op = p;
      endcase
    end
  endfunction

  // variable right shift, saturating at four places
  function [47:0] rshift;
    input [47:0] v;
    input [2:0]  amt;
    input        sgn;
    reg   [2:0]  a;
    begin
      a = (amt > `MACS_SHIFT_MAX) ? `MACS_SHIFT_MAX : amt;
      if (sgn)
        rshift = $signed(v) >>> a;
      else
        rshift = v >> a;
    end
  endfunction

  // sign extension of the operands, as chosen by the captured signedness
  wire sg = o_signed_ff;

  // normal mode product, operands straight from the data inputs
  wire [47:0] n_a = {{29{sg & i_data_a[18]}}, i_data_a};
  wire [47:0] n_b = {{30{sg & i_data_b[17]}}, i_data_b};
  wire [47:0] n_p = n_a * n_b;                             // kept mod 2^48, the stage width

  // dual mode products: 11x10 in the low lane, 8x8 in the high lane
  wire [23:0] d_a0 = {{13{sg & i_data_a[10]}}, i_data_a[10:0]};
  wire [23:0] d_b0 = {{14{sg & i_data_b[9]}}, i_data_b[9:0]};
  wire [23:0] d_a1 = {{16{sg & i_data_a[18]}}, i_data_a[18:11]};
  wire [23:0] d_b1 = {{16{sg & i_data_b[17]}}, i_data_b[17:10]};
  wire [23:0] d_p0 = d_a0 * d_b0;
  wire [23:0] d_p1 = d_a1 * d_b1;

  // quad mode products: 7x6 in lane 0, 4x4 in lanes 1 to 3
  wire [11:0] q_a0 = {{5{sg & i_data_a[6]}}, i_data_a[6:0]};
  wire [11:0] q_b0 = {{6{sg & i_data_b[5]}}, i_data_b[5:0]};
  wire [11:0] q_a1 = {{8{sg & i_data_a[10]}}, i_data_a[10:7]};
  wire [11:0] q_b1 = {{8{sg & i_data_b[9]}}, i_data_b[9:6]};
  wire [11:0] q_a2 = {{8{sg & i_data_a[14]}}, i_data_a[14:11]};
  wire [11:0] q_b2 = {{8{sg & i_data_b[13]}}, i_data_b[13:10]};
  wire [11:0] q_a3 = {{8{sg & i_data_a[18]}}, i_data_a[18:15]};
  wire [11:0] q_b3 = {{8{sg & i_data_b[17]}}, i_data_b[17:14]};
  wire [11:0] q_p0 = q_a0 * q_b0;
  wire [11:0] q_p1 = q_a1 * q_b1;
  wire [11:0] q_p2 = q_a2 * q_b2;
  wire [11:0] q_p3 = q_a3 * q_b3;

  // products packed lane by lane into one word
  reg  [47:0] prod_pk;
  reg  [47:0] mask;
  reg  [47:0] pk;
  reg  [47:0] ck;
  reg  [47:0] ak;
  reg  [47:0] tk;
  integer     k;
  integer     lw;
  integer     nl;

  // brain-float working values
  reg               f_sp;
  reg               f_sc;
  reg               f_sr;
  reg signed [10:0] f_ep;
  reg signed [10:0] f_ec;
  reg signed [10:0] f_eb;
  reg signed [10:0] f_er;
  reg        [15:0] f_mp;
  reg        [15:0] f_c;
  reg        [23:0] f_big;
  reg        [23:0] f_sml;
  reg        [24:0] f_sum;
  reg        [24:0] f_nrm;
  reg        [10:0] f_dif;
  reg        [15:0] f_res;
  integer           f_ld;
  integer           i;

  // fused bf16 multiply-add: the product keeps all 16 bits unless alignment shifts it right by more than 8 places
  always @*
  begin
    f_sp  = i_data_a[15] ^ i_data_b[15];
    f_ep  = $signed({3'h0, i_data_a[14:7]}) + $signed({3'h0, i_data_b[14:7]}) - `MACS_BF_BIAS;
    f_mp  = {1'b1, i_data_a[6:0]} * {1'b1, i_data_b[6:0]};
    if ((i_data_a[14:7] == 8'h00) || (i_data_b[14:7] == 8'h00))
      f_mp = 16'h0000;                                     // zero or denormal operand
    case (i_op)
      `MACS_OP_ADD: f_c = i_addend[15:0];
      `MACS_OP_SUB: f_c = {~i_addend[15], i_addend[14:0]};
      `MACS_OP_ACC: f_c = acc_ff[15:0];
      default:      f_c = 16'h0000;                        // product only
    endcase
    f_sc  = f_c[15];
    f_ec  = $signed({3'h0, f_c[14:7]});
    // align the smaller operand to the larger exponent
    if (f_mp == 16'h0000 || (f_c[14:7] != 8'h00 && f_ec > f_ep))
    begin
      f_eb  = f_ec;
      f_sr  = f_sc;
      f_big = (f_c[14:7] == 8'h00) ? 24'h00_0000 : {2'h1, f_c[6:0], 15'h0000};
      f_dif = f_ec - f_ep;
      f_sml = (f_dif > 11'd23) ? 24'h00_0000 : ({f_mp, 8'h00} >> f_dif);
      f_sml = (f_mp == 16'h0000) ? 24'h00_0000 : f_sml;
    end
    else
    begin
      f_eb  = f_ep;
      f_sr  = f_sp;
      f_big = {f_mp, 8'h00};
      f_dif = f_ep - f_ec;
      f_sml = (f_dif > 11'd23 || f_c[14:7] == 8'h00) ? 24'h00_0000 :
              ({2'h1, f_c[6:0], 15'h0000} >> f_dif);
    end
    // add or subtract magnitudes; the larger magnitude sets the sign
    if (f_sp == f_sc)
      f_sum = {1'b0, f_big} + {1'b0, f_sml};
    else if (f_big >= f_sml)
      f_sum = {1'b0, f_big} - {1'b0, f_sml};
    else
    begin
      f_sum = {1'b0, f_sml} - {1'b0, f_big};
      f_sr  = ~f_sr;
    end
    // find the leading one and renormalise
    f_ld = 0;
    for (i = 0; i < 25; i = i + 1)
      if (f_sum[i])
        f_ld = i;
    f_nrm = f_sum << (24 - f_ld);
    f_er  = f_eb + f_ld[10:0] - `MACS_BF_POINT;
    if (f_sum == 25'h000_0000 || f_er <= 11'sh000)
      f_res = 16'h0000;                                    // flush to zero
    else if (f_er >= `MACS_BF_EXP_MAX)
      f_res = {f_sr, 8'hff, 7'h00};                        // overflow to infinity
    else
      f_res = {f_sr, f_er[7:0], f_nrm[23:17]};
  end

  // integer lanes: pack products, run each lane's add stage and shifter
  always @*
  begin
    case (o_mode_ff)
      `MACS_MODE_DUAL:
      begin
        nl      = 2;
        lw      = `MACS_DUAL_LW;
        prod_pk = {d_p1[23:0], d_p0[23:0]};
      end
      `MACS_MODE_QUAD:
      begin
        nl      = 4;
        lw      = `MACS_QUAD_LW;
        prod_pk = {q_p3[11:0], q_p2[11:0], q_p1[11:0], q_p0[11:0]};
      end
      default:
      begin
        nl      = 1;
        lw      = `MACS_RES_W;
        prod_pk = n_p[47:0];
      end
    endcase
    mask    = {48{1'b1}} >> (`MACS_RES_W - lw);
    nxt_acc = `MACS_RES_RST;
    nxt_res = `MACS_RES_RST;
    pk      = 48'h0000_0000_0000;
    ck      = 48'h0000_0000_0000;
    ak      = 48'h0000_0000_0000;
    tk      = 48'h0000_0000_0000;
    for (k = 0; k < 4; k = k + 1)
    begin
      if (k < nl)
      begin
        pk = (prod_pk >> (k * lw)) & mask;
        ck = (i_addend >> (k * lw)) & mask;
        ak = (acc_ff >> (k * lw)) & mask;
        // optional add, subtract or accumulate stage
        tk = lane_op(i_op, pk, ck, ak) & mask;
        nxt_acc = nxt_acc | (tk << (k * lw));
        // extend to full width so the shifter sees the lane's own sign
        if (sg && tk[lw-1])
          tk = tk | ~mask;
        tk = rshift(tk, i_shift_amt[k*`MACS_SHAMT_W +: `MACS_SHAMT_W], sg) & mask;
        nxt_res = nxt_res | (tk << (k * lw));
      end
    end
    if (o_mode_ff == `MACS_MODE_FLOAT)
    begin
      nxt_acc = {32'h0000_0000, f_res};
      nxt_res = {32'h0000_0000, f_res};
    end
  end

  // configuration is captured only while reset is held, then frozen
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      o_mode_ff   <= i_mode;
      o_signed_ff <= i_signed;
    end
  end

  // result and accumulator registers, updated on each accepted request
  always @(posedge i_clk_sys)
  begin
    if (i_sys_rst)
    begin
      acc_ff      <= `MACS_RES_RST;
      o_result_ff <= `MACS_RES_RST;
      o_valid_ff  <= 1'b0;
    end
    else
    begin
      o_valid_ff <= i_valid;
      if (i_valid)
      begin
        acc_ff      <= nxt_acc;
        o_result_ff <= nxt_res;
      end
    end
  end

endmodule

// file: pkg/macs_consts.vh
`ifndef MACS_CONSTS_VH
`define MACS_CONSTS_VH

// operating modes
`define MACS_MODE_NORMAL   2'h0
`define MACS_MODE_DUAL     2'h1
`define MACS_MODE_QUAD     2'h2
`define MACS_MODE_FLOAT    2'h3

// add stage operations
`define MACS_OP_PASS       2'h0
`define MACS_OP_ADD        2'h1
`define MACS_OP_SUB        2'h2
`define MACS_OP_ACC        2'h3

// datapath widths
`define MACS_A_W           19
`define MACS_B_W           18
`define MACS_RES_W         48
`define MACS_DUAL_LW       24
`define MACS_QUAD_LW       12
`define MACS_SHAMT_W       3
`define MACS_SHIFT_MAX     3'h4

// lane packing of the operand inputs
`define MACS_DUAL_A0_W     11
`define MACS_DUAL_B0_W     10
`define MACS_QUAD_A0_W     7
`define MACS_QUAD_B0_W     6

// brain-float fields
`define MACS_BF_BIAS       11'sh07f
`define MACS_BF_EXP_MAX    11'sh0ff
`define MACS_BF_POINT      11'sh016

// reset values
`define MACS_RES_RST       48'h0000_0000_0000
`define MACS_MODE_RST      2'h0

`endif

// file: testbench/macs_slice_asserts.sv
module macs_slice_chk
(
  // slice ports as seen from outside
  input logic        i_clk_sys,
  input logic        i_sys_rst,
  input logic [1:0]  i_mode,
  input logic        i_signed,
  input logic        i_valid,
  input logic [1:0]  i_op,
  input logic [18:0] i_data_a,
  input logic [17:0] i_data_b,
  input logic [47:0] i_addend,
  input logic [11:0] i_shift_amt,
  input logic        o_valid_ff,
  input logic [47:0] o_result_ff,
  input logic [1:0]  o_mode_ff,
  input logic        o_signed_ff
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [47:0] prod;
  logic [47:0] exp_prod;
  logic [47:0] exp_sum;
  logic [2:0]  amt;
  logic        nrm;
  // unsigned wide product and saturated lane 0 shift
  assign prod = {29'h0, i_data_a} * {30'h0, i_data_b};
  assign amt = (i_shift_amt[2:0] > 3'h4) ? 3'h4 : i_shift_amt[2:0];
  assign nrm = o_mode_ff == 2'h0 && !o_signed_ff && i_valid;
  // expected words, held as signals so that the checks delay plain signals
  assign exp_prod = prod >> amt;
  assign exp_sum = prod + i_addend;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  AST_ANSWER: assert property (i_valid |=> o_valid_ff)
    else $error("answer missing");
  AST_QUIET: assert property (!i_valid |=> !o_valid_ff && $stable(o_result_ff))
    else $error("output moved without request");
  AST_CFG_HOLD: assert property ($stable({o_mode_ff, o_signed_ff}))
    else $error("configuration changed while running");
  AST_CFG_TAKE: assert property (disable iff (1'b0) i_sys_rst |=>
    o_mode_ff == $past(i_mode) && o_signed_ff == $past(i_signed))
    else $error("configuration not captured");
  AST_CLEAR: assert property (disable iff (1'b0) i_sys_rst |=>
    !o_valid_ff && o_result_ff == 48'h0)
    else $error("reset did not clear");
  AST_PROD: assert property (nrm && i_op == 2'h0 |=> o_result_ff == $past(exp_prod))
    else $error("shifted product wrong");
  AST_ADD: assert property (nrm && i_op == 2'h1 && amt == 3'h0
    |=> o_result_ff == $past(exp_sum))
    else $error("sum wrong");
  AST_FLOAT: assert property (o_mode_ff == 2'h3 && i_valid |=> o_result_ff[47:16] == 32'h0)
    else $error("float upper bits set");
endmodule

bind macs_slice macs_slice_chk chk (.i_clk_sys, .i_sys_rst, .i_mode, .i_signed, .i_valid,
  .i_op, .i_data_a, .i_data_b, .i_addend, .i_shift_amt, .o_valid_ff, .o_result_ff,
  .o_mode_ff, .o_signed_ff);

// file: testbench/macs_fabric.sv
module macs_fabric
(
  // bench clock
  input  logic        i_clk_sys,
  // lines toward the slice
  output logic        o_rst,
  output logic [1:0]  o_mode,
  output logic        o_signed,
  output logic        o_valid,
  output logic [1:0]  o_op,
  output logic [18:0] o_a,
  output logic [17:0] o_b,
  output logic [47:0] o_c,
  output logic [11:0] o_sh
);
  timeunit 1ns;
  timeprecision 100ps;
  // reset asserted from time zero
  initial
  begin
    {o_rst, o_mode, o_signed, o_valid, o_op} = 7'h40;
    {o_a, o_b, o_c, o_sh} = '0;
  end
  // reset with one signedness for every lane
  task automatic cfg(input logic [1:0] m, input logic s);
    @(posedge i_clk_sys) #1;
    o_rst = 1'b1;
    o_mode = m;
    o_signed = s;
    repeat (20) @(posedge i_clk_sys);
    #1 o_rst = 1'b0;
  endtask
  // one strobe, operands a, b and c inverted afterwards
  task automatic issue(input logic [1:0] op, input logic [18:0] a, input logic [17:0] b,
                       input logic [47:0] c, input logic [11:0] sh);
    @(posedge i_clk_sys) #1;
    o_valid = 1'b1;
    o_op = op;
    o_a = a;
    o_b = b;
    o_c = c;
    o_sh = sh;
    @(posedge i_clk_sys) #1;
    o_valid = 1'b0;
    {o_a, o_b, o_c} = ~{o_a, o_b, o_c};
  endtask
endmodule

// file: testbench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clk_sys = 1'b0;
  logic        i_sys_rst, i_signed, i_valid, o_valid_ff, o_signed_ff;
  logic [1:0]  i_mode, i_op, o_mode_ff;
  logic [18:0] i_data_a;
  logic [17:0] i_data_b;
  logic [47:0] i_addend, o_result_ff, p;
  logic [11:0] i_shift_amt;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;

  // 25 MHz clock
  always #20 i_clk_sys = ~i_clk_sys;

  macs_fabric fab (.i_clk_sys(i_clk_sys), .o_rst(i_sys_rst), .o_mode(i_mode),
    .o_signed(i_signed), .o_valid(i_valid), .o_op(i_op), .o_a(i_data_a), .o_b(i_data_b),
    .o_c(i_addend), .o_sh(i_shift_amt));
  macs_slice uut (.i_clk_sys, .i_sys_rst, .i_mode, .i_signed, .i_valid, .i_op, .i_data_a,
    .i_data_b, .i_addend, .i_shift_amt, .o_valid_ff, .o_result_ff, .o_mode_ff, .o_signed_ff);

  // compare one result word
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // request, then check strobe and result
  task automatic rq(input logic [1:0] op, input logic [18:0] a, input logic [17:0] b,
                    input logic [47:0] c, input logic [11:0] sh, input logic [47:0] exp);
    fab.issue(op, a, b, c, sh);
    chk({47'h0, o_valid_ff}, 48'h1);
    chk(o_result_ff, exp);
  endtask
  // hang guard
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      fail_count++;
      close_out();
    end
  end
  // test sequence
  initial
  begin
    p = 48'h7_ffff * 48'h3_ffff;
    fab.cfg(2'h0, 1'b0);
    rq(2'h0, 19'h7_ffff, 18'h3_ffff, 48'h0, 12'h000, p);
    rq(2'h0, 19'h7_ffff, 18'h3_ffff, 48'h0, 12'h002, p >> 2);
    rq(2'h0, 19'h7_ffff, 18'h3_ffff, 48'h0, 12'h007, p >> 4);
    rq(2'h1, 19'h7_ffff, 18'h3_ffff, 48'hffff_ffff_ffff, 12'h000, p - 48'h1);
    rq(2'h2, 19'h7_ffff, 18'h3_ffff, 48'h1, 12'h001, (p - 48'h1) >> 1);
    rq(2'h3, 19'h7_ffff, 18'h3_ffff, 48'h0, 12'h000, 48'h2 * p - 48'h1);
    $display("normal test done");
    fab.cfg(2'h0, 1'b1);
    rq(2'h0, 19'h7_ffff, 18'h0_0002, 48'h0, 12'h001, 48'hffff_ffff_ffff);
    fab.cfg(2'h1, 1'b0);
    rq(2'h1, 19'h7_ffff, 18'h3_ffff, 48'hffff_ffff_ffff, 12'h000,
       {24'h00_00ff * 24'h00_00ff + 24'hff_ffff, 24'h00_07ff * 24'h00_03ff + 24'hff_ffff});
    fab.cfg(2'h2, 1'b0);
    rq(2'h2, 19'h7_ffff, 18'h3_ffff, {{3{12'h001}}, 12'hfff}, 12'h010,
       {{2{12'h0e0}}, 12'h038, 12'h07f * 12'h03f - 12'hfff});
    fab.cfg(2'h2, 1'b1);
    rq(2'h0, 19'h7_ffff, 18'h0_8882, 48'h0, 12'h1c9, {12'hffe, {3{12'hfff}}});
    $display("lane test done");
    fab.cfg(2'h3, 1'b0);
    fab.o_mode = 2'h0;
    rq(2'h1, 19'h0_3f80, 18'h0_4000, 48'h3f80, 12'h000, 48'h4040);
    rq(2'h0, 19'h0_3f80, 18'h0_4000, 48'h3f80, 12'h000, 48'h4000);
    rq(2'h2, 19'h0_3f80, 18'h0_4000, 48'h3f80, 12'h000, 48'h3f80);
    rq(2'h3, 19'h0_3f80, 18'h0_4000, 48'h0, 12'h000, 48'h4040);
    chk({45'h0, o_mode_ff, o_signed_ff}, 48'h6);
    $display("float test done");
    close_out();
  end
endmodule
